// ---- hw/payload_queue.v ----
// Operation
// - pipes 2..5 each hold a six-bit payload byte count, 1 to 32.
// - count zero marks pipe unused; counts reset to zero.
// - read-only resend flag sits in status bit 6.
// - with resend flag set, last packet repeats while chip enable high.
// - resend command sets flag; payload write or tx flush clears it.
// - status bit 5 shows tx queue full, resets to 0.
// - status bit 4 shows tx queue empty, resets to 1.
// - status bit 1 shows rx queue full, resets to 0.
// - status bit 0 shows rx queue empty, resets to 1.
// - tx payload queue is write-only, three entries of up to 32 bytes.
// - payloads move only by payload commands, never by register address.
// - rx payload queue is read-only, three entries, drained by host.
// - all six receive pipes share one rx queue.
`include "payload_queue_defines.vh"

module payload_queue #(
    parameter DEPTH = `QUEUE_DEPTH,
    parameter PW    = `PAYLOAD_BITS
) (
    input  wire          sys_clk,
    input  wire          rst,
    input  wire          clk_en,
    input  wire          chip_enable,
    input  wire          cmd_valid,
    input  wire [2:0]    cmd_op,
    input  wire [4:0]    cmd_addr,
    input  wire [7:0]    cmd_wdata,
    input  wire [PW-1:0] cmd_payload,
    input  wire [5:0]    cmd_payload_len,
    output reg  [7:0]    reg_rdata,
    output reg           reg_rvalid,
    output reg           tx_out_valid,
    input  wire          tx_out_ready,
    output reg  [PW-1:0] tx_out_data,
    output reg  [5:0]    tx_out_len,
    input  wire          rx_in_valid,
    output reg           rx_in_ready,
    input  wire [2:0]    rx_in_pipe,
    input  wire [PW-1:0] rx_in_data,
    input  wire [5:0]    rx_in_len,
    output reg           rx_out_valid,
    input  wire          rx_out_ready,
    output reg  [PW-1:0] rx_out_data,
    output reg  [5:0]    rx_out_len,
    output reg  [2:0]    rx_out_pipe
);

    localparam EW = PW + 6;
    localparam RW = PW + 9;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    // every op is qualified by clk_en, so a frozen block ignores the host
    wire do_cmd    = cmd_valid & clk_en;
    wire op_rd     = do_cmd & (cmd_op == `OP_READ_REG);
    wire op_wr     = do_cmd & (cmd_op == `OP_WRITE_REG);
    wire op_txw    = do_cmd & (cmd_op == `OP_WRITE_PAYLOAD);
    wire op_ftx    = do_cmd & (cmd_op == `OP_FLUSH_TX);
    wire op_frx    = do_cmd & (cmd_op == `OP_FLUSH_RX);
    wire op_resend = do_cmd & (cmd_op == `OP_RESEND);

    // ----------------------------------------------------------------
    // per-pipe payload lengths, pipes 2..5
    // ----------------------------------------------------------------
    // one register per pipe, each with a single driver, read through a net array
    wire [5:0] pipe_len [0:3];
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : pipe_len_gen
            reg [5:0] len;
            // only the low six bits are stored; reserved bits read zero
            always @(posedge sys_clk)
            begin
                if (rst)
                    len <= `LENGTH_RESET;
                else if (op_wr && cmd_addr == `PIPE2_PAYLOAD_LENGTH_ADDR + g)
                    len <= cmd_wdata[`LENGTH_MSB:0];
            end
            assign pipe_len[g] = len;
        end
    endgenerate

    // ----------------------------------------------------------------
    // transmit queue
    // ----------------------------------------------------------------
    reg [EW-1:0] tx_mem [0:DEPTH-1];
    reg [1:0]    tx_wp;
    reg [1:0]    tx_rp;
    reg [1:0]    tx_cnt;
    reg          resend_flag;
    reg          tx_have_last;

    wire tx_full  = (tx_cnt == DEPTH);
    wire tx_empty = (tx_cnt == 2'h0);
    wire tx_sent  = tx_out_valid & tx_out_ready;
    // a write to a full queue is dropped; payload enters only by command
    wire tx_push  = op_txw & ~tx_full;
    // pop only into a free or draining stage; a set resend flag keeps the old word
    wire tx_pop   = clk_en & ~op_ftx & ~resend_flag & chip_enable & ~tx_empty
                    & (~tx_out_valid | tx_sent);

    // queue storage and pointers
    // pointers wrap at DEPTH-1; a flush resets them outright
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            tx_wp  <= 2'h0;
            tx_rp  <= 2'h0;
            tx_cnt <= 2'h0;
        end
        else if (op_ftx)
        begin
            tx_wp  <= 2'h0;
            tx_rp  <= 2'h0;
            tx_cnt <= 2'h0;
        end
        else if (clk_en)
        begin
            if (tx_push)
            begin
                tx_mem[tx_wp] <= {cmd_payload_len, cmd_payload};
                tx_wp         <= (tx_wp == DEPTH - 1) ? 2'h0 : tx_wp + 2'h1;
            end
            if (tx_pop)
                tx_rp <= (tx_rp == DEPTH - 1) ? 2'h0 : tx_rp + 2'h1;
            if (tx_push && !tx_pop)
                tx_cnt <= tx_cnt + 2'h1;
            else if (tx_pop && !tx_push)
                tx_cnt <= tx_cnt - 2'h1;
        end
    end

    // resend flag: set by the resend command, cleared by write or flush
    // one op per cycle, so set and clear never meet at one edge
    always @(posedge sys_clk)
    begin
        if (rst)
            resend_flag <= 1'b0;
        else if (op_resend)
            resend_flag <= 1'b1;
        else if (op_txw || op_ftx)
            resend_flag <= 1'b0;
    end

    // outgoing stage keeps the last sent packet so it can be resent
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            tx_out_valid <= 1'b0;
            tx_out_data  <= {PW{1'b0}};
            tx_out_len   <= 6'h00;
            tx_have_last <= 1'b0;
        end
        else if (clk_en)
        begin
            if (tx_pop)
            begin
                tx_out_valid <= 1'b1;
                {tx_out_len, tx_out_data} <= tx_mem[tx_rp];
                tx_have_last <= 1'b1;
            end
            // flush first, so a flushed word drops at once; a later resend command can show it again
            else if (op_ftx)
                tx_out_valid <= 1'b0;
            else if (resend_flag && tx_have_last)
                tx_out_valid <= chip_enable;
            else if (tx_sent)
                tx_out_valid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // receive queue, shared by every pipe
    // ----------------------------------------------------------------
    reg [RW-1:0] rx_mem [0:DEPTH-1];
    reg [1:0]    rx_wp;
    reg [1:0]    rx_rp;
    reg [1:0]    rx_cnt;
    reg [5:0]    in_len;

    // pipes 0 and 1 bring their own length; 2..5 use the stored counts
    // pipe p reads slot p-2 of the length registers
    always @*
    begin
        in_len = rx_in_len;
        if (rx_in_pipe >= 3'h2 && rx_in_pipe <= 3'h5)
            in_len = pipe_len[rx_in_pipe[1:0] - 2'h2];
    end

    wire rx_full   = (rx_cnt == DEPTH);
    wire rx_empty  = (rx_cnt == 2'h0);
    wire rx_take   = clk_en & rx_in_valid & rx_in_ready;
    // an unused pipe's packet is accepted and discarded
    wire rx_push   = rx_take & (in_len != 6'h00) & ~op_frx;
    wire buf_space;
    reg  rx_pop_prev;
    // pop only when the output buffer is sure to have room
    wire rx_pop    = clk_en & ~op_frx & ~rx_empty & buf_space;

    // queue storage and pointers
    // a flush clears the queue here and the output buffer below
    always @(posedge sys_clk)
    begin
        if (rst || (clk_en && op_frx))
        begin
            rx_wp  <= 2'h0;
            rx_rp  <= 2'h0;
            rx_cnt <= 2'h0;
        end
        else if (clk_en)
        begin
            if (rx_push)
            begin
                rx_mem[rx_wp] <= {rx_in_pipe, in_len, rx_in_data};
                rx_wp         <= (rx_wp == DEPTH - 1) ? 2'h0 : rx_wp + 2'h1;
            end
            if (rx_pop)
                rx_rp <= (rx_rp == DEPTH - 1) ? 2'h0 : rx_rp + 2'h1;
            if (rx_push && !rx_pop)
                rx_cnt <= rx_cnt + 2'h1;
            else if (rx_pop && !rx_push)
                rx_cnt <= rx_cnt - 2'h1;
        end
    end

    // ready is registered; it looks ahead at the count after this edge
    // after a push into the second slot ready drops for a cycle: one lost
    // cycle, but a registered ready can never overrun the queue
    reg [1:0] next_rx_cnt;
    always @*
    begin
        next_rx_cnt = rx_cnt;
        if (op_frx)
            next_rx_cnt = 2'h0;
        else if (rx_push && !rx_pop)
            next_rx_cnt = rx_cnt + 2'h1;
        else if (rx_pop && !rx_push)
            next_rx_cnt = rx_cnt - 2'h1;
    end

    always @(posedge sys_clk)
    begin
        if (rst)
            rx_in_ready <= 1'b0;
        else if (clk_en)
            rx_in_ready <= (next_rx_cnt < DEPTH - 1) ||
                           (next_rx_cnt == DEPTH - 1 && !rx_push);
    end

    // ----------------------------------------------------------------
    // two-entry buffer toward the host
    // ----------------------------------------------------------------
    // holds two so a host stall never drops a popped payload
    reg [RW-1:0] buf_spare;
    reg [1:0]    buf_cnt;
    wire         out_take = rx_out_valid & rx_out_ready;
    // right after a pop with no take, hold off one cycle; slower, but never overfills
    assign buf_space = (buf_cnt == 2'h0) || (buf_cnt == 2'h1 && !rx_pop_prev);

    always @(posedge sys_clk)
    begin
        if (rst || (clk_en && op_frx))
        begin
            buf_cnt      <= 2'h0;
            rx_out_valid <= 1'b0;
            rx_pop_prev  <= 1'b0;
            rx_out_pipe  <= 3'h0;
            rx_out_len   <= 6'h00;
            rx_out_data  <= {PW{1'b0}};
        end
        else if (clk_en)
        begin
            rx_pop_prev <= 1'b0;
            case ({rx_pop, out_take})
                2'b10:
                begin
                    if (buf_cnt == 2'h0)
                        {rx_out_pipe, rx_out_len, rx_out_data} <= rx_mem[rx_rp];
                    else
                        buf_spare <= rx_mem[rx_rp];
                    buf_cnt      <= buf_cnt + 2'h1;
                    rx_out_valid <= 1'b1;
                    rx_pop_prev  <= 1'b1;
                end
                2'b01:
                begin
                    if (buf_cnt == 2'h2)
                        {rx_out_pipe, rx_out_len, rx_out_data} <= buf_spare;
                    buf_cnt      <= buf_cnt - 2'h1;
                    rx_out_valid <= (buf_cnt == 2'h2);
                end
                2'b11:
                begin
                    if (buf_cnt == 2'h2)
                    begin
                        {rx_out_pipe, rx_out_len, rx_out_data} <= buf_spare;
                        buf_spare <= rx_mem[rx_rp];
                    end
                    else
                        {rx_out_pipe, rx_out_len, rx_out_data} <= rx_mem[rx_rp];
                end
                default:
                    buf_cnt <= buf_cnt;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    // payload stores have no address; unmapped reads return zero
    // status bits 7, 3 and 2 are reserved and read zero
    // address low bits 3, 0, 1, 2 select pipes 2, 3, 4, 5
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else if (clk_en)
        begin
            reg_rvalid <= op_rd;
            if (op_rd)
            begin
                if (cmd_addr >= `PIPE2_PAYLOAD_LENGTH_ADDR &&
                    cmd_addr <= `PIPE5_PAYLOAD_LENGTH_ADDR)
                    reg_rdata <= {2'h0, pipe_len[cmd_addr[1:0] - 2'h3]};
                else if (cmd_addr == `QUEUE_STATE_ADDR)
                    reg_rdata <= {1'b0, resend_flag, tx_full, tx_empty,
                                  2'h0, rx_full, rx_empty};
                else
                    reg_rdata <= 8'h00;
            end
        end
    end

endmodule

// ---- hw/payload_queue_defines.vh ----
`ifndef PAYLOAD_QUEUE_DEFINES_VH
`define PAYLOAD_QUEUE_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PIPE2_PAYLOAD_LENGTH_ADDR 5'h13
`define PIPE3_PAYLOAD_LENGTH_ADDR 5'h14
`define PIPE4_PAYLOAD_LENGTH_ADDR 5'h15
`define PIPE5_PAYLOAD_LENGTH_ADDR 5'h16
`define QUEUE_STATE_ADDR          5'h17

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define LENGTH_MSB        5
`define LENGTH_RESET      6'h00
`define RESEND_FLAG_BIT   6
`define TX_FULL_BIT       5
`define TX_EMPTY_BIT      4
`define RX_FULL_BIT       1
`define RX_EMPTY_BIT      0
`define QUEUE_STATE_RESET 8'h11

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define OP_READ_REG       3'h0
`define OP_WRITE_REG      3'h1
`define OP_WRITE_PAYLOAD  3'h2
`define OP_FLUSH_TX       3'h3
`define OP_FLUSH_RX       3'h4
`define OP_RESEND         3'h5

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define QUEUE_DEPTH       3
`define PAYLOAD_BITS      256
`define PAYLOAD_MAX_BYTES 6'h20

`endif

// ---- test/payload_queue_assertions.sv ----
// --------
// port checks
// --------
module payload_queue_assertions #(
    parameter DEPTH = 3,
    parameter PW    = 256
) (
    input wire          sys_clk,
    input wire          rst,
    input wire          clk_en,
    input wire          chip_enable,
    input wire          cmd_valid,
    input wire [2:0]    cmd_op,
    input wire [4:0]    cmd_addr,
    input wire [7:0]    reg_rdata,
    input wire          reg_rvalid,
    input wire          tx_out_valid,
    input wire          tx_out_ready,
    input wire [PW-1:0] tx_out_data,
    input wire          rx_in_valid,
    input wire          rx_in_ready,
    input wire [2:0]    rx_in_pipe,
    input wire          rx_out_valid,
    input wire          rx_out_ready,
    input wire [PW-1:0] rx_out_data,
    input wire [2:0]    rx_out_pipe
);
    // commands taken this edge; a flush may drop a held word
    wire rd  = cmd_valid && clk_en && cmd_op == 3'h0;
    wire tfl = cmd_valid && clk_en && cmd_op == 3'h3;
    wire rfl = cmd_valid && clk_en && cmd_op == 3'h4;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (rd |=> reg_rvalid)
        else $error("read not answered");
    a_no_stray_answer: assert property (reg_rvalid |-> $past(rd))
        else $error("answer without read");
    a_rdata_holds: assert property (!rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_unmapped_zero: assert property (rd && (cmd_addr < 5'h13 || cmd_addr > 5'h17)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_length_top_zero: assert property (rd && cmd_addr inside {[5'h13:5'h16]}
        |=> reg_rdata[7:6] == 2'b00)
        else $error("length bits 7:6 set");
    a_tx_word_stands: assert property (tx_out_valid && !tx_out_ready && !tfl
        |=> tx_out_valid && $stable(tx_out_data))
        else $error("tx word lost");
    a_tx_needs_enable: assert property ($rose(tx_out_valid)
        |-> $past(chip_enable) || $past(chip_enable, 2))
        else $error("tx without chip enable");
    a_rx_word_stands: assert property (rx_out_valid && !rx_out_ready && !rfl
        |=> rx_out_valid && $stable(rx_out_data) && $stable(rx_out_pipe))
        else $error("rx word lost");
    a_rx_latency: assert property (rx_in_valid && rx_in_ready && rx_in_pipe < 3'h2
        && !rx_out_valid && !rfl |-> ##[1:2] rx_out_valid)
        else $error("rx word late");
    a_reset_quiet: assert property ($fell(rst)
        |-> !tx_out_valid && !rx_out_valid && !reg_rvalid)
        else $error("outputs busy after reset");
    cover property (tx_out_valid && tx_out_ready);
    cover property (rx_out_valid && rx_out_ready);
    cover property (rx_in_valid && !rx_in_ready);
endmodule

bind payload_queue payload_queue_assertions #(.DEPTH(DEPTH), .PW(PW)) chk (.*);

// ---- test/host_model.sv ----
// --------
// host command driver
// --------
module host_model (
    input  wire          sys_clk,
    output logic         chip_enable,
    output logic         cmd_valid,
    output logic [2:0]   cmd_op,
    output logic [4:0]   cmd_addr,
    output logic [7:0]   cmd_wdata,
    output logic [255:0] cmd_payload,
    output logic [5:0]   cmd_payload_len,
    input  wire  [7:0]   reg_rdata,
    input  wire          reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle at time zero
    initial
    begin
        chip_enable = 1'b0;
        {cmd_valid, cmd_op, cmd_addr, cmd_wdata, cmd_payload, cmd_payload_len} = '0;
    end
    // one strobe; qualifiers except the payload length turn to junk once it drops
    task send(input [2:0] op, input [4:0] a, input [7:0] w, input [255:0] p, input [5:0] n);
        @(negedge sys_clk);
        {cmd_valid, cmd_op, cmd_addr, cmd_wdata, cmd_payload, cmd_payload_len}
            = {1'b1, op, a, w, p, n};
        @(negedge sys_clk);
        {cmd_valid, cmd_op, cmd_addr, cmd_wdata, cmd_payload} = {1'b0, ~op, ~a, ~w, ~p};
    endtask
    // reserved top bits always written as zero
    task write_len(input [4:0] a, input [5:0] n);
        send(3'h1, a, {2'b00, n}, '0, 6'h00);
    endtask
    // raised only after the payload is loaded
    task set_ce(input v);
        @(negedge sys_clk);
        chip_enable = v;
    endtask
    // bounded wait so a silent design cannot hang the run
    task read(input [4:0] a, output [7:0] d);
        send(3'h0, a, 8'h00, '0, 6'h00);
        for (int k = 0; k < 4 && reg_rvalid !== 1'b1; k++)
            @(negedge sys_clk);
        d = reg_rvalid === 1'b1 ? reg_rdata : 8'hXX;
    endtask
endmodule

// ---- test/test_payload_queue.sv ----
module test_payload_queue;
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // signals
    // --------
    logic sys_clk = 1'b0, rst = 1'b1, tx_out_ready = 1'b0, rx_out_ready = 1'b0;
    logic rx_in_valid = 1'b0, rx_drain = 1'b0, clk_en = 1'b1;
    logic [2:0] rx_in_pipe = 3'h0;
    logic [5:0] rx_in_len = 6'h00;
    logic [255:0] rx_in_data = '0;
    logic [31:0] seed = 32'h2A722B22;
    logic [5:0] plen [2:5];
    logic [264:0] txq [$], rxq [$], last_tx = 'x;
    int err_count = 0, compares = 0, cycles = 0, tx_seen = 0;
    wire chip_enable, cmd_valid, reg_rvalid, tx_out_valid, rx_in_ready, rx_out_valid;
    wire [2:0] cmd_op, rx_out_pipe;
    wire [4:0] cmd_addr;
    wire [7:0] cmd_wdata, reg_rdata;
    wire [5:0] cmd_payload_len, tx_out_len, rx_out_len;
    wire [255:0] cmd_payload, tx_out_data, rx_out_data;
    payload_queue DUT (.*);
    host_model host (.*);
    // clock, hang guard and random back-pressure
    initial forever #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            complete_run();
        end
    end
    always @(negedge sys_clk)
    begin
        tx_out_ready <= rnd() % 4 != 0;
        rx_out_ready <= rx_drain && rnd() % 2;
    end
    // words leaving the block against what was queued
    always @(posedge sys_clk)
    begin
        if (!rst && clk_en && tx_out_valid && tx_out_ready)
        begin
            if (txq.size() > 0)
                last_tx = txq.pop_front();
            check_pkt(last_tx, {3'h0, tx_out_len, tx_out_data});
            tx_seen++;
        end
        if (!rst && clk_en && rx_out_valid && rx_out_ready)
            check_pkt(rxq.size() > 0 ? rxq.pop_front() : 'x,
                {rx_out_pipe, rx_out_len, rx_out_data});
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [255:0] rpay();
        logic [255:0] p;
        for (int i = 0; i < 8; i++)
            p[i*32 +: 32] = rnd();
        return p;
    endfunction
    // fixed-width pipes take their stored count
    function automatic logic [5:0] rx_len(input [2:0] pipe, input [5:0] n);
        return pipe < 3'h2 ? n : plen[pipe];
    endfunction
    task check_reg(input string what, input [7:0] e, input [7:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task check_pkt(input [264:0] e, input [264:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("Error packet expected %h seen %h", e, g);
        end
    endtask
    // hold the word until taken, then scramble the lines
    task push_rx(input [2:0] pipe, input [5:0] n, input [255:0] d);
        @(negedge sys_clk);
        {rx_in_valid, rx_in_pipe, rx_in_len, rx_in_data} = {1'b1, pipe, n, d};
        for (int k = 0; k < 50 && rx_in_ready !== 1'b1; k++)
            @(negedge sys_clk);
        @(negedge sys_clk);
        {rx_in_valid, rx_in_pipe, rx_in_len, rx_in_data} = {1'b0, ~pipe, ~n, ~d};
        if (rx_len(pipe, n) != 6'h00)
            rxq.push_back({pipe, rx_len(pipe, n), d});
    endtask
    task wait_empty();
        for (int k = 0; k < 400 && (txq.size() > 0 || rxq.size() > 0); k++)
            @(negedge sys_clk);
        repeat (4) @(negedge sys_clk);
    endtask
    task complete_run();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // --------
    // main sequence
    // --------
    initial
    begin
        logic [7:0] d;
        logic [255:0] p;
        logic [5:0] n;
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        for (int a = 19; a < 24; a++)
        begin
            host.read(5'(a), d);
            check_reg("reset value", a == 23 ? 8'h11 : 8'h00, d);
        end
        host.read(5'h05, d);
        check_reg("unmapped", 8'h00, d);
        for (int i = 2; i < 6; i++)
        begin
            plen[i] = i == 5 ? 6'h00 : i == 4 ? 6'h20 : 6'(rnd() % 32 + 1);
            host.write_len(5'(17 + i), plen[i]);
            host.read(5'(17 + i), d);
            check_reg("length", {2'b00, plen[i]}, d);
        end
        // fourth payload must be dropped while sending is held off
        for (int i = 0; i < 4; i++)
        begin
            p = rpay();
            n = 6'(rnd() % 32 + 1);
            if (i < 3)
                txq.push_back({3'h0, n, p});
            host.send(3'h2, 5'h00, 8'h00, p, n);
        end
        host.read(5'h17, d);
        check_reg("tx full", 8'h21, d);
        host.set_ce(1'b1);
        wait_empty();
        host.send(3'h5, 5'h00, 8'h00, '0, 6'h00);
        host.read(5'h17, d);
        check_reg("resend set", 8'h51, d);
        tx_seen = 0;
        repeat (40) @(negedge sys_clk);
        check_reg("resend repeats", 8'h01, {7'h00, tx_seen > 2});
        host.send(3'h3, 5'h00, 8'h00, '0, 6'h00);
        host.set_ce(1'b0);
        host.read(5'h17, d);
        check_reg("flush", 8'h11, d);
        host.send(3'h5, 5'h00, 8'h00, '0, 6'h00);
        p = rpay();
        txq.push_back({3'h0, 6'h20, p});
        host.send(3'h2, 5'h00, 8'h00, p, 6'h20);
        host.read(5'h17, d);
        check_reg("write clears", 8'h01, d);
        host.set_ce(1'b1);
        wait_empty();
        // zero-length pipe first, then fill queue and buffer
        for (int i = 0; i < 6; i++)
            push_rx(3'((i + 5) % 6), 6'(rnd() % 32 + 1), rpay());
        repeat (4) @(negedge sys_clk);
        check_reg("rx refused", 8'h00, {7'h00, rx_in_ready});
        host.read(5'h17, d);
        check_reg("rx full", 8'h12, d);
        rx_drain = 1'b1;
        wait_empty();
        host.read(5'h17, d);
        check_reg("rx drained", 8'h11, d);
        // a flush empties queue and output buffer alike
        rx_drain = 1'b0;
        push_rx(3'h0, 6'h05, rpay());
        host.send(3'h4, 5'h00, 8'h00, '0, 6'h00);
        rxq.delete();
        host.read(5'h17, d);
        check_reg("rx flushed", 8'h11, d);
        rx_drain = 1'b1;
        repeat (8) @(negedge sys_clk);
        // a frozen block takes no command
        clk_en = 1'b0;
        host.write_len(5'h13, plen[2] ^ 6'h01);
        host.send(3'h5, 5'h00, 8'h00, '0, 6'h00);
        clk_en = 1'b1;
        host.read(5'h13, d);
        check_reg("frozen length", {2'b00, plen[2]}, d);
        host.read(5'h17, d);
        check_reg("frozen resend", 8'h11, d);
        complete_run();
    end
endmodule
